// ==== hw/vca_pkg.sv ====
package vca_pkg;
   localparam int VCA_DATA_W = 8;
   localparam int VCA_FIFO_DEPTH = 16;
   localparam int VCA_FIFO_AW = 4;
   localparam int VCA_WORD_W = 9;
   localparam int VCA_TAG_BIT = 8;
   localparam int VCA_OFS_W = 10;
   localparam logic [9:0] VCA_OFS_MAX = 10'h30A;
   localparam logic [9:0] VCA_OFS_ZERO = 10'h000;
   localparam logic [3:0] VCA_NDF_ON = 4'h9;
   localparam logic [3:0] VCA_NDF_OFF = 4'h6;
   localparam logic [1:0] VCA_SS_SDH = 2'h2;
   localparam logic [1:0] VCA_SS_SONET = 2'h0;
   localparam logic [1:0] VCA_HOLD_FRAMES = 2'h3;
   localparam logic [1:0] VCA_AIS_FRAMES = 2'h3;
   localparam logic [7:0] VCA_ONES = 8'hFF;
   localparam logic [9:0] VCA_I_MASK = 10'h2AA;
   localparam logic [9:0] VCA_D_MASK = 10'h155;
   localparam logic [4:0] VCA_FILL_RESET = 5'h00;
   typedef enum logic [2:0] {
      VCA_ST_STEADY = 3'b000,
      VCA_ST_ALARM = 3'b001,
      VCA_ST_NEWPTR = 3'b010,
      VCA_ST_POSJ = 3'b011,
      VCA_ST_NEGJ = 3'b100
   } vca_state_t;
endpackage

// ==== hw/vca_fifo.sv ====
`timescale 1ns/1ns
module vca_fifo
   import vca_pkg::*;
#(
   parameter int WIDTH = VCA_WORD_W,
   parameter int DEPTH = VCA_FIFO_DEPTH,
   parameter int AW = VCA_FIFO_AW
) (
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o,
   output logic [AW:0] fill_o
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   assign fill_o = wr_q - rd_q;
   assign in_ready_o = (fill_o != (AW+1)'(DEPTH));
   assign out_valid_o = (fill_o != '0);
   assign out_data_o = mem[rd_q[AW-1:0]];
   always_ff @(posedge clk_sys_i) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data_i;
      end
   end
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (flush_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule

// ==== hw/vca_ptr_fmt.sv ====
`timescale 1ns/1ns
module vca_ptr_fmt
   import vca_pkg::*;
(
   input wire logic [3:0] ndf_i,
   input wire logic sdh_mode_i,
   input wire logic [9:0] value_i,
   input wire logic all_ones_i,
   output logic [7:0] h1_o,
   output logic [7:0] h2_o
);
   wire [1:0] ss = sdh_mode_i ? VCA_SS_SDH : VCA_SS_SONET;
   wire [15:0] word = {ndf_i, ss, value_i};
   assign h1_o = all_ones_i ? VCA_ONES : word[15:8];
   assign h2_o = all_ones_i ? VCA_ONES : word[7:0];
endmodule

// ==== hw/vca_aligner.sv ====
`timescale 1ns/1ns
// Notes on behaviour
// - outgoing pointer follows phase between incoming and outgoing overhead, adjusted by justifications
// - every incoming payload byte incl. path overhead enters the store at incoming rate
// - each store word is one data byte plus a J1 marker bit
// - write also on negative stuff byte on negative justification; skip positive stuff byte on positive justification
// - read on outgoing negative stuff when decrementing; skip outgoing positive stuff when incrementing
// - fill under low threshold asks increment, over high threshold asks decrement
// - overflow or underflow detected; optionally path AIS sent for three frames
// - pointer generator makes H1/H2; one shared machine for mixed concatenations
// - five states; steady leaves for justify or new pointer only at an outgoing frame start
// - alarm entry and exit follow upstream interpreter alarm, lost or valid
// - justify and new-pointer states return to steady by themselves after one pointer
// - justify request counts only if last action over three frames ago
// - offset break on incoming enabled new data flag or store overflow/underflow
// - increment: flag off, I bits inverted, stuff after H3, offset plus one
// - decrement: flag off, D bits inverted, data in H3, offset minus one
// - new pointer: adopt new offset, send flag on with that offset
// - steady: flag off with current active offset
// - alarm: pointer and payload all ones, offset undefined
// - new data flag nibble 1001 when on, 0110 when off
// - SS bits 10 in SDH mode
module vca_aligner
   import vca_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic resetn_i,
   input wire logic [4:0] fill_low_i,
   input wire logic [4:0] fill_high_i,
   input wire logic slip_ais_en_i,
   input wire logic sdh_mode_i,
   input wire logic in_byte_i,
   input wire logic [7:0] in_data_i,
   input wire logic in_j1_i,
   input wire logic in_neg_stuff_i,
   input wire logic in_pos_stuff_i,
   input wire logic in_neg_just_i,
   input wire logic in_pos_just_i,
   input wire logic in_new_pointer_i,
   input wire logic [9:0] in_offset_i,
   input wire logic upstream_pointer_alarm_i,
   input wire logic upstream_pointer_lost_i,
   input wire logic upstream_pointer_valid_i,
   input wire logic out_frame_i,
   input wire logic out_h1_i,
   input wire logic out_h2_i,
   input wire logic out_h3_i,
   input wire logic out_after_h3_i,
   input wire logic out_payload_i,
   output logic [7:0] out_data_o,
   output logic out_j1_o,
   output logic out_valid_o,
   output logic [2:0] state_o,
   output logic [9:0] active_offset_o,
   output logic slip_event_o,
   output logic alarm_event_o
);
   vca_state_t state_q, state_d;
   logic [9:0] ofs_q, ofs_d;
   logic [9:0] new_ofs_q;
   logic [1:0] hold_q;
   logic [1:0] ais_q;
   logic break_q;
   logic [7:0] data_q;
   logic j1_q;
   logic valid_q;
   logic slip_q;
   logic alarm_ev_q;
   logic [4:0] fill;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [8:0] fifo_word;
   logic [7:0] ptr_h1, ptr_h2;
   logic [3:0] ndf_sel;
   logic [9:0] ptr_val;

   // bounded wrap keeps the offset legal across justifications
   function automatic logic [9:0] ofs_step(input logic [9:0] v, input logic up);
      if (up) begin
         ofs_step = (v == VCA_OFS_MAX) ? VCA_OFS_ZERO : v + 10'h001;
      end else begin
         ofs_step = (v == VCA_OFS_ZERO) ? VCA_OFS_MAX : v - 10'h001;
      end
   endfunction

   // write side: the negative stuff byte is part of the stream only on negative justification, the positive one except on positive justification
   wire wr_byte = in_byte_i && (!in_pos_stuff_i || !in_pos_just_i)
                  && (!in_neg_stuff_i || in_neg_just_i);
   wire wr_req = wr_byte;
   wire overflow = wr_req && !fifo_in_ready;
   wire in_alarm = (state_q == VCA_ST_ALARM);
   // read side: payload bytes, plus H3 on decrement, minus after-H3 on increment
   wire rd_slot = (out_payload_i && !(out_after_h3_i && state_q == VCA_ST_POSJ))
                  || (out_h3_i && state_q == VCA_ST_NEGJ);
   wire rd_req = rd_slot && !in_alarm;
   wire underflow = rd_req && !fifo_out_valid;
   wire slip = overflow || underflow;
   wire frame_break = in_new_pointer_i || slip || break_q;
   wire hold_done = (hold_q == '0);
   wire fill_low_event = (fill < fill_low_i) && hold_done;
   wire fill_high_event = (fill > fill_high_i) && hold_done;
   wire upstream_bad = upstream_pointer_alarm_i || upstream_pointer_lost_i;
   wire ais_out = in_alarm || (ais_q != '0);

   vca_fifo #(
      .WIDTH(VCA_WORD_W),
      .DEPTH(VCA_FIFO_DEPTH),
      .AW(VCA_FIFO_AW)
   ) u_elastic_store (
      .clk_sys_i(clk_sys_i),
      .resetn_i(resetn_i),
      .flush_i(slip),
      .in_valid_i(wr_req),
      .in_ready_o(fifo_in_ready),
      .in_data_i({in_j1_i, in_data_i}),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(rd_req),
      .out_data_o(fifo_word),
      .fill_o(fill)
   );

   // pointer pattern per state
   assign ndf_sel = (state_q == VCA_ST_NEWPTR) ? VCA_NDF_ON : VCA_NDF_OFF;
   assign ptr_val = (state_q == VCA_ST_POSJ) ? (ofs_q ^ VCA_I_MASK) :
                    (state_q == VCA_ST_NEGJ) ? (ofs_q ^ VCA_D_MASK) :
                    ofs_q;

   vca_ptr_fmt u_ptr_fmt (
      .ndf_i(ndf_sel),
      .sdh_mode_i(sdh_mode_i),
      .value_i(ptr_val),
      .all_ones_i(ais_out),
      .h1_o(ptr_h1),
      .h2_o(ptr_h2)
   );

   // one shared machine; channel slots come from the frame timing inputs
   always_comb begin
      state_d = state_q;
      ofs_d = ofs_q;
      case (state_q)
         VCA_ST_STEADY: begin
            if (upstream_bad) begin
               state_d = VCA_ST_ALARM;
            end else if (out_frame_i && frame_break) begin
               state_d = VCA_ST_NEWPTR;
            end else if (out_frame_i && fill_low_event) begin
               state_d = VCA_ST_POSJ;
            end else if (out_frame_i && fill_high_event) begin
               state_d = VCA_ST_NEGJ;
            end
         end
         VCA_ST_ALARM: begin
            if (upstream_pointer_valid_i && !upstream_bad) begin
               state_d = VCA_ST_NEWPTR;
            end
         end
         VCA_ST_NEWPTR: begin
            if (out_frame_i) begin
               state_d = VCA_ST_STEADY;
            end
         end
         VCA_ST_POSJ: begin
            if (out_frame_i) begin
               state_d = VCA_ST_STEADY;
               ofs_d = ofs_step(ofs_q, 1'b1);
            end
         end
         VCA_ST_NEGJ: begin
            if (out_frame_i) begin
               state_d = VCA_ST_STEADY;
               ofs_d = ofs_step(ofs_q, 1'b0);
            end
         end
         default: begin
            state_d = VCA_ST_ALARM;
         end
      endcase
      if (upstream_bad && state_q != VCA_ST_ALARM) begin
         state_d = VCA_ST_ALARM;
      end
      if (state_d == VCA_ST_NEWPTR && state_q != VCA_ST_NEWPTR) begin
         ofs_d = new_ofs_q;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= VCA_ST_ALARM;
         ofs_q <= VCA_OFS_ZERO;
      end else begin
         state_q <= state_d;
         ofs_q <= ofs_d;
      end
   end

   // latest incoming phase is the candidate for the next new pointer
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         new_ofs_q <= VCA_OFS_ZERO;
      end else if (in_new_pointer_i || in_j1_i) begin
         new_ofs_q <= in_offset_i;
      end
   end

   // a break seen mid-frame waits for the next frame boundary; set wins over clear
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         break_q <= 1'b0;
      end else if (in_new_pointer_i || slip) begin
         break_q <= 1'b1;
      end else if (state_q == VCA_ST_NEWPTR) begin
         break_q <= 1'b0;
      end
   end

   // frames left to wait after the last justification, new pointer or alarm
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         hold_q <= VCA_HOLD_FRAMES;
      end else if (out_frame_i && state_q != VCA_ST_STEADY) begin
         hold_q <= VCA_HOLD_FRAMES;
      end else if (out_frame_i && !hold_done) begin
         hold_q <= hold_q - 2'h1;
      end
   end

   // slip AIS lasts three outgoing frames; a slip during it restarts the count
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ais_q <= '0;
      end else begin
         if (slip && slip_ais_en_i) begin
            ais_q <= VCA_AIS_FRAMES;
         end else if (out_frame_i && ais_q != '0) begin
            ais_q <= ais_q - 2'h1;
         end
      end
   end

   // output byte: pointer, justification slots, payload or all ones
   wire [7:0] pay_byte = ais_out ? VCA_ONES : fifo_word[VCA_DATA_W-1:0];
   wire [7:0] out_sel = out_h1_i ? ptr_h1 :
                        out_h2_i ? ptr_h2 :
                        pay_byte;
   wire out_any = out_h1_i || out_h2_i || rd_req || (out_payload_i && ais_out);

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         data_q <= VCA_ONES;
         j1_q <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         data_q <= out_sel;
         j1_q <= rd_req && fifo_word[VCA_TAG_BIT] && !ais_out;
         valid_q <= out_any;
      end
   end

   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         slip_q <= 1'b0;
         alarm_ev_q <= 1'b0;
      end else begin
         slip_q <= slip;
         alarm_ev_q <= (state_d == VCA_ST_ALARM) != (state_q == VCA_ST_ALARM);
      end
   end

   assign out_data_o = data_q;
   assign out_j1_o = j1_q;
   assign out_valid_o = valid_q;
   assign state_o = state_q;
   assign active_offset_o = ofs_q;
   assign slip_event_o = slip_q;
   assign alarm_event_o = alarm_ev_q;

   a_upstream_alarm: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      upstream_bad |=> state_q == VCA_ST_ALARM)
      else $error("alarm not entered");
   a_posj_returns: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_q == VCA_ST_POSJ && out_frame_i && !upstream_bad) |=> state_q == VCA_ST_STEADY)
      else $error("increment did not return");
   a_negj_returns: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_q == VCA_ST_NEGJ && out_frame_i && !upstream_bad) |=> state_q == VCA_ST_STEADY)
      else $error("decrement did not return");
   a_newptr_returns: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_q == VCA_ST_NEWPTR && out_frame_i && !upstream_bad) |=> state_q == VCA_ST_STEADY)
      else $error("new pointer did not return");
   a_posj_offset: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_q == VCA_ST_POSJ && out_frame_i && !upstream_bad) |=> ofs_q == ofs_step($past(ofs_q), 1'b1))
      else $error("offset not incremented");
   a_negj_offset: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_q == VCA_ST_NEGJ && out_frame_i && !upstream_bad) |=> ofs_q == ofs_step($past(ofs_q), 1'b0))
      else $error("offset not decremented");
   a_posj_h2: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_q == VCA_ST_POSJ && !ais_out && out_h2_i) |=> out_data_o == ($past(ofs_q[7:0]) ^ VCA_I_MASK[7:0]))
      else $error("increment pointer wrong");
   a_negj_h2: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_q == VCA_ST_NEGJ && !ais_out && out_h2_i) |=> out_data_o == ($past(ofs_q[7:0]) ^ VCA_D_MASK[7:0]))
      else $error("decrement pointer wrong");
   a_negj_read: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_q == VCA_ST_NEGJ && out_h3_i && fifo_out_valid && !wr_req) |=> fill == $past(fill) - 5'h01)
      else $error("no read in stuff slot");
   a_newptr_offset: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_d == VCA_ST_NEWPTR && state_q != VCA_ST_NEWPTR) |=> ofs_q == $past(new_ofs_q))
      else $error("new offset not adopted");
   a_steady_offset: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_q == VCA_ST_STEADY && state_d == VCA_ST_STEADY) |=> $stable(ofs_q))
      else $error("steady offset moved");
   a_alarm_ones: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (in_alarm && (out_h1_i || out_payload_i)) |=> out_data_o == VCA_ONES)
      else $error("alarm bytes not all ones");
   a_alarm_h2: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (in_alarm && out_h2_i) |=> out_data_o == VCA_ONES)
      else $error("alarm second byte not all ones");
   a_ndf_steady: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_q == VCA_ST_STEADY && !ais_out && out_h1_i) |=> out_data_o[7:4] == VCA_NDF_OFF)
      else $error("steady flag wrong");
   a_ndf_new: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_q == VCA_ST_NEWPTR && !ais_out && out_h1_i) |=> out_data_o[7:4] == VCA_NDF_ON)
      else $error("new pointer flag wrong");
   a_ss_sdh: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (sdh_mode_i && !ais_out && out_h1_i) |=> out_data_o[3:2] == VCA_SS_SDH)
      else $error("ss bits wrong");
   a_hold_gate: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_q == VCA_ST_STEADY && hold_q != '0) |=> (state_q != VCA_ST_POSJ && state_q != VCA_ST_NEGJ))
      else $error("justification too soon");
   a_fill_low: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_q == VCA_ST_STEADY && out_frame_i && !upstream_bad && !frame_break && hold_done && fill < fill_low_i)
      |=> state_q == VCA_ST_POSJ) else $error("increment not started");
   a_fill_high: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (state_q == VCA_ST_STEADY && out_frame_i && !upstream_bad && !frame_break && hold_done && !(fill < fill_low_i)
      && fill > fill_high_i) |=> state_q == VCA_ST_NEGJ) else $error("decrement not started");
   a_slip_ais: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (slip && slip_ais_en_i) |=> ais_q == VCA_AIS_FRAMES)
      else $error("slip AIS not started");
   a_slip_flush: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      slip |=> fill == '0)
      else $error("store not emptied after slip");
   a_slip_event: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      slip |=> slip_event_o)
      else $error("slip event missing");
   a_alarm_event: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      $changed(in_alarm) |-> alarm_event_o)
      else $error("alarm event missing");
   a_j1_valid: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      out_j1_o |-> out_valid_o)
      else $error("marker without valid byte");
endmodule

// ==== tb/vca_line_model.sv ====
`timescale 1ns/1ns
// far side: upstream receive path and its pointer interpreter
module vca_line_model (
   input wire logic clk_sys_i,
   output logic byte_o,
   output logic [7:0] data_o,
   output logic j1_o,
   output logic neg_stuff_o,
   output logic pos_stuff_o,
   output logic neg_just_o,
   output logic pos_just_o,
   output logic new_ptr_o,
   output logic [9:0] offset_o,
   output logic alarm_o,
   output logic lost_o,
   output logic valid_o
);
   initial begin
      {byte_o, j1_o, neg_stuff_o, pos_stuff_o, neg_just_o, pos_just_o, new_ptr_o} = 7'h00;
      data_o = 8'h5A;
      offset_o = 10'h000;
      {alarm_o, lost_o, valid_o} = 3'h2;
   end
   // one burst; justification level spans the burst, the stuff strobe marks byte sidx
   task automatic send(input int n, input logic [7:0] base, input logic j1, input int sidx, input logic neg);
      for (int i = 0; i < n; i++) begin
         @(negedge clk_sys_i);
         byte_o = 1'b1;
         data_o = base + 8'(i);
         j1_o = j1 && (i == 0);
         neg_just_o = (sidx >= 0) && neg;
         pos_just_o = (sidx >= 0) && !neg;
         neg_stuff_o = (i == sidx) && neg;
         pos_stuff_o = (i == sidx) && !neg;
      end
      @(negedge clk_sys_i);
      {byte_o, j1_o, neg_stuff_o, pos_stuff_o, neg_just_o, pos_just_o} = 6'h00;
      // idle lane shows the inverse so a stale byte never passes for a fresh one
      data_o = ~data_o;
   endtask
   task automatic new_pointer(input logic [9:0] ofs);
      @(negedge clk_sys_i);
      new_ptr_o = 1'b1;
      offset_o = ofs;
      @(negedge clk_sys_i);
      new_ptr_o = 1'b0;
   endtask
   task automatic set_cond(input logic [2:0] c);
      @(negedge clk_sys_i);
      {alarm_o, lost_o, valid_o} = c;
   endtask
endmodule

// ==== tb/tb_vca_aligner.sv ====
`timescale 1ns/1ns
module tb_vca_aligner
   import vca_pkg::*;
;
   logic clk_sys_i;
   logic resetn_i;
   logic [4:0] fill_low, fill_high;
   logic slip_ais_en, sdh_mode;
   logic [5:0] st; // frame, h1, h2, h3, after_h3, payload
   logic byte_w, j1_w, nst_w, pst_w, nj_w, pj_w, np_w, al_w, lo_w, va_w;
   logic [7:0] data_w, out_data;
   logic [9:0] ofs_w, act_ofs;
   logic out_j1, out_valid, slip_ev, alarm_ev;
   logic [2:0] state;
   int errors, compares;

   vca_line_model m (.clk_sys_i(clk_sys_i), .byte_o(byte_w), .data_o(data_w), .j1_o(j1_w),
      .neg_stuff_o(nst_w), .pos_stuff_o(pst_w), .neg_just_o(nj_w), .pos_just_o(pj_w), .new_ptr_o(np_w),
      .offset_o(ofs_w), .alarm_o(al_w), .lost_o(lo_w), .valid_o(va_w));

   vca_aligner uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .fill_low_i(fill_low), .fill_high_i(fill_high),
      .slip_ais_en_i(slip_ais_en), .sdh_mode_i(sdh_mode), .in_byte_i(byte_w), .in_data_i(data_w), .in_j1_i(j1_w),
      .in_neg_stuff_i(nst_w), .in_pos_stuff_i(pst_w), .in_neg_just_i(nj_w), .in_pos_just_i(pj_w),
      .in_new_pointer_i(np_w), .in_offset_i(ofs_w), .upstream_pointer_alarm_i(al_w),
      .upstream_pointer_lost_i(lo_w), .upstream_pointer_valid_i(va_w), .out_frame_i(st[5]), .out_h1_i(st[4]),
      .out_h2_i(st[3]), .out_h3_i(st[2]), .out_after_h3_i(st[1]), .out_payload_i(st[0]),
      .out_data_o(out_data), .out_j1_o(out_j1), .out_valid_o(out_valid), .state_o(state),
      .active_offset_o(act_ofs), .slip_event_o(slip_ev), .alarm_event_o(alarm_ev));

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic check(input string name, input logic [9:0] e, input logic [9:0] g);
      compares++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", name, e, g);
      end
   endtask
   task automatic chk_state(input logic [2:0] e);
      check("state", {7'h00, e}, {7'h00, state});
   endtask
   // strobe one slot; registered output is settled by the next falling edge
   task automatic slot(input int k, output logic [7:0] d, output logic j);
      @(negedge clk_sys_i);
      st[k] = 1'b1;
      @(negedge clk_sys_i);
      st[k] = 1'b0;
      d = out_data;
      j = out_j1;
   endtask
   task automatic ex(input string name, input int k, input logic [7:0] e);
      logic [7:0] d;
      logic j;
      slot(k, d, j);
      check(name, {2'h0, e}, {2'h0, d});
      check("valid", 10'h001, {9'h000, out_valid});
   endtask
   task automatic frame;
      logic [7:0] d;
      logic j;
      slot(5, d, j);
   endtask

   task automatic t_reset;
      chk_state(VCA_ST_ALARM);
      check("offset", 10'h000, act_ofs);
      check("reset data", 10'h0FF, {2'h0, out_data});
   endtask
   task automatic t_alarm;
      ex("alarm h1", 4, VCA_ONES);
      ex("alarm h2", 3, VCA_ONES);
      ex("alarm payload", 0, VCA_ONES);
   endtask
   task automatic t_recover;
      m.new_pointer(10'h123);
      m.set_cond(3'h1);
      @(negedge clk_sys_i);
      chk_state(VCA_ST_NEWPTR);
      check("alarm exit", 10'h001, {9'h000, alarm_ev});
      ex("newptr h1", 4, {VCA_NDF_ON, VCA_SS_SDH, 2'h1});
      ex("newptr h2", 3, 8'h23);
      check("offset", 10'h123, act_ofs);
      frame();
      chk_state(VCA_ST_STEADY);
      ex("steady h1", 4, {VCA_NDF_OFF, VCA_SS_SDH, 2'h1});
      sdh_mode = 1'b0;
      ex("sonet h1", 4, {VCA_NDF_OFF, VCA_SS_SONET, 2'h1});
      sdh_mode = 1'b1;
   endtask
   task automatic t_fifo;
      logic [8:0] exp_w [6] = '{9'h1A0, 9'h0A2, 9'h0A3, 9'h0B0, 9'h0B1, 9'h0B2};
      logic [7:0] d;
      logic j;
      m.send(4, 8'hA0, 1'b1, 1, 1'b0);
      m.send(3, 8'hB0, 1'b0, 1, 1'b1);
      for (int i = 0; i < 6; i++) begin
         slot(0, d, j);
         check("fifo word", {1'b0, exp_w[i]}, {1'b0, j, d});
      end
   endtask
   task automatic t_just;
      repeat (4) frame();
      check("frame valid", 10'h000, {9'h000, out_valid});
      chk_state(VCA_ST_STEADY);
      fill_low = 5'h05;
      frame();
      chk_state(VCA_ST_POSJ);
      ex("posj h1", 4, {VCA_NDF_OFF, VCA_SS_SDH, 2'h3});
      ex("posj h2", 3, 8'h89);
      frame();
      chk_state(VCA_ST_STEADY);
      check("offset", 10'h124, act_ofs);
      frame();
      chk_state(VCA_ST_STEADY);
      fill_low = 5'h00;
   endtask
   // hold count from the increment must run out before the decrement is taken
   task automatic t_negj;
      logic [7:0] d;
      logic j;
      fill_high = 5'h02;
      m.send(3, 8'hC0, 1'b0, -1, 1'b0);
      frame();
      frame();
      chk_state(VCA_ST_STEADY);
      frame();
      chk_state(VCA_ST_NEGJ);
      ex("negj h1", 4, {VCA_NDF_OFF, VCA_SS_SDH, 2'h0});
      ex("negj h2", 3, 8'h71);
      ex("negj h3", 2, 8'hC0);
      frame();
      chk_state(VCA_ST_STEADY);
      check("offset", 10'h123, act_ofs);
      fill_high = 5'h10;
      for (int i = 1; i < 3; i++) begin
         slot(0, d, j);
         check("drain", {2'h0, 8'hC0 + 8'(i)}, {2'h0, d});
      end
   endtask
   task automatic t_rereset;
      @(negedge clk_sys_i);
      resetn_i = 1'b0;
      repeat (2) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      t_reset();
   endtask
   task automatic t_slip;
      logic seen;
      seen = 1'b0;
      slip_ais_en = 1'b1;
      m.send(16, 8'h40, 1'b0, -1, 1'b0);
      check("slip early", 10'h000, {9'h000, slip_ev});
      m.send(1, 8'h50, 1'b0, -1, 1'b0);
      repeat (4) begin
         if (slip_ev === 1'b1) seen = 1'b1;
         @(negedge clk_sys_i);
      end
      check("slip", 10'h001, {9'h000, seen});
      frame();
      chk_state(VCA_ST_NEWPTR);
      ex("ais payload", 0, VCA_ONES);
   endtask
   task automatic t_lost;
      logic seen;
      seen = 1'b0;
      m.set_cond(3'h2);
      repeat (4) begin
         if (alarm_ev === 1'b1) seen = 1'b1;
         @(negedge clk_sys_i);
      end
      check("alarm event", 10'h001, {9'h000, seen});
      chk_state(VCA_ST_ALARM);
   endtask

   task automatic print_verdict;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // whole run needs well under a thousand cycles
   initial begin
      #200000;
      errors++;
      $display("unexpected watchdog expected done seen hang");
      print_verdict();
   end

   initial begin
      errors = 0;
      compares = 0;
      resetn_i = 1'b0;
      st = 6'h00;
      fill_low = 5'h00;
      fill_high = 5'h10;
      slip_ais_en = 1'b0;
      sdh_mode = 1'b1;
      repeat (20) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      t_reset();
      t_alarm();
      t_recover();
      t_fifo();
      t_just();
      t_negj();
      t_slip();
      t_lost();
      t_rereset();
      print_verdict();
   end
endmodule
